// *** core/dpram_host_pkg.sv ***
`default_nettype none
package dpram_host_pkg;
   // widths of one device port
   localparam int ADDR_W = 13;
   localparam int DATA_W = 18;
   localparam int REG_AW = 4;
   localparam int REG_DW = 32;
   localparam int CNT_W = 8;
   localparam int TOK_COUNT = 8;
   localparam int TOK_SEL_W = 3;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets of the command port
   localparam logic [REG_AW-1:0] REG_CMD = 4'h0;
   localparam logic [REG_AW-1:0] REG_ADDR = 4'h1;
   localparam logic [REG_AW-1:0] REG_WDATA = 4'h2;
   localparam logic [REG_AW-1:0] REG_RDATA = 4'h3;
   localparam logic [REG_AW-1:0] REG_STATUS = 4'h4;
   localparam logic [REG_AW-1:0] REG_CONFIG = 4'h5;

   // field positions
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_OP_W = 3;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_OWNED = 2;
   localparam int ST_SPREAD_ERR = 3;
   localparam int ST_BUSY_SEEN = 4;
   localparam int CFG_INHIBIT = 0;
   localparam logic CFG_INHIBIT_RST = 1'b0;

   // semaphore token values, active low
   localparam logic TOK_TAKE = 1'b0;
   localparam logic TOK_FREE = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // timing, in ns, and the clock period
   localparam int CLK_PERIOD_NS = 4;
   localparam int SETUP_NS = 15;
   localparam int ACCESS_NS = 15;
   localparam int RECOVER_NS = 8;

   // commands
   typedef enum logic [CMD_OP_W-1:0] {
      OP_MEM_RD = 3'h0,
      OP_MEM_WR = 3'h1,
      OP_TOK_RD = 3'h2,
      OP_TOK_WR = 3'h3,
      OP_ACQUIRE = 3'h4,
      OP_INIT = 3'h5
   } op_type;

   // control pins toward one device port, all active low
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic chipEnN;
      logic tokenSpaceSelectN;
      logic rwN;
      logic outEnN;
   } pins_type;

   localparam pins_type PINS_IDLE = '{addr: '0, chipEnN: 1'b1,
      tokenSpaceSelectN: 1'b1, rwN: 1'b1, outEnN: 1'b1};

   // least time in ns to whole cycles, at least one
   function automatic logic [CNT_W-1:0] ns_to_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return c[CNT_W-1:0];
   endfunction : ns_to_cycles

   localparam logic [CNT_W-1:0] SETUP_CYC = ns_to_cycles(SETUP_NS);
   localparam logic [CNT_W-1:0] ACCESS_CYC = ns_to_cycles(ACCESS_NS);
   localparam logic [CNT_W-1:0] RECOVER_CYC = ns_to_cycles(RECOVER_NS);
endpackage : dpram_host_pkg
`default_nettype wire

// *** core/dpram_port_host.sv ***
// Device rules this block works with
// RQ1 - device lets one same-address access through, flags busy low to other
// RQ2 - write from the busy-flagged port is blocked inside the device
// RQ3 - slave part does not arbitrate; busy is only a write inhibit input
// RQ4 - in slave mode host holds busy high normally, low to block writes
// RQ5 - master part drives busy push-pull on both levels
// RQ6 - master busy depends only on chip enables and addresses
// RQ7 - hold address and enable long enough before starting a write pulse
// RQ8 - a width-expanded array uses exactly one master part
// RQ9 - eight semaphore latches live apart from the memory array
// RQ10 - request token by writing zero, release by writing one, same port
// RQ11 - semaphore select low picks token space; low three address bits
// RQ12 - semaphore write uses data bit zero only
// RQ13 - zero written to free token reads zero here, one on the far side
// RQ14 - owned token changes only from the owning port
// RQ15 - owner writing one frees token unless the far side is pending
// RQ16 - non-owner zero stays pending in its request latch
// RQ17 - semaphore read spreads the flag onto every data bit
// RQ18 - read value latched while select and output enable stay active
// RQ19 - polling must drop select or output enable between reads
// RQ20 - chip enable and semaphore select both high gives standby
// RQ21 - tokens have no hardware effect on memory access
// RQ22 - master never drives both busy outputs low together
// RQ23 - concurrent requests for a free token give it to exactly one port
// RQ24 - release with far side pending passes ownership at once
// RQ25 - role strap is static: master drives busy, slave samples it
// RQ26 - busy compares full address, only when both chip enables active
`default_nettype none
module dpram_port_host
   import dpram_host_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   // command port
   input wire logic [REG_AW-1:0] regAddr,
   input wire logic [REG_DW-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [REG_DW-1:0] regRdData,
   // device port pins
   input wire logic roleMaster,
   output pins_type pins,
   input wire logic [DATA_W-1:0] dataIn,
   output logic [DATA_W-1:0] dataOut,
   output logic dataOe,
   input wire logic busyIn,
   output logic busyOut,
   output logic busyOe
);
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_SETUP = 2'b01,
      S_STROBE = 2'b10,
      S_RECOVER = 2'b11
   } state_type;

   state_type state_r, state_nxt;
   op_type op_r, op_nxt;
   logic isWrite_r, isWrite_nxt;
   logic isTok_r, isTok_nxt;
   pins_type pins_r, pins_nxt;
   logic [DATA_W-1:0] wrData_r, wrData_nxt;
   logic [DATA_W-1:0] dataOut_r, dataOut_nxt;
   logic dataOe_r, dataOe_nxt;
   logic [ADDR_W-1:0] addrReg_r, addrReg_nxt;
   logic [DATA_W-1:0] wdataReg_r, wdataReg_nxt;
   logic [DATA_W-1:0] rdataReg_r, rdataReg_nxt;
   logic done_r, done_nxt;
   logic owned_r, owned_nxt;
   logic spreadErr_r, spreadErr_nxt;
   logic busySeen_r, busySeen_nxt;
   logic inhibit_r, inhibit_nxt;
   logic [REG_DW-1:0] regRdData_r, regRdData_nxt;
   logic tmrLoad;
   logic [CNT_W-1:0] tmrValue;
   logic tmrExpired;
   logic startCmd;
   logic seqDone;

   ////////////////////////////////////////////////////////////////////////////
   // phase timer
   pin_timer #(.W(CNT_W)) u_timer (
      .clk(clk),
      .reset(reset),
      .load(tmrLoad),
      .loadValue(tmrValue),
      .expired(tmrExpired)
   );

   // true when the read value is one flag spread on all bits
   function automatic logic spread_ok(input logic [DATA_W-1:0] d);
      return (d == '0) || (d == '1);
   endfunction : spread_ok

   // pins for one phase of an access
   function automatic pins_type phase_pins(input logic [ADDR_W-1:0] a,
                                           input logic tok,
                                           input logic wr,
                                           input logic strobe);
      pins_type p;
      p = PINS_IDLE;
      p.addr = a;
      p.chipEnN = tok;          // memory access uses chip enable
      p.tokenSpaceSelectN = ~tok;
      p.rwN = ~(wr & strobe);
      p.outEnN = ~(~wr & strobe);
      return p;
   endfunction : phase_pins

   assign startCmd = regWrStb && (regAddr == REG_CMD) && (state_r == S_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // access sequencer
   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      isWrite_nxt = isWrite_r;
      isTok_nxt = isTok_r;
      pins_nxt = pins_r;
      wrData_nxt = wrData_r;
      dataOut_nxt = dataOut_r;
      dataOe_nxt = dataOe_r;
      addrReg_nxt = addrReg_r;
      rdataReg_nxt = rdataReg_r;
      owned_nxt = owned_r;
      spreadErr_nxt = spreadErr_r;
      tmrLoad = 1'b0;
      tmrValue = SETUP_CYC;
      seqDone = 1'b0;
      unique case (state_r)
         S_IDLE: begin
            pins_nxt = PINS_IDLE;  // both selects high: standby [RQ20]
            dataOe_nxt = 1'b0;
            if (startCmd) begin
               op_nxt = op_type'(regWrData[CMD_OP_LSB +: CMD_OP_W]);
               isTok_nxt = (op_nxt != OP_MEM_RD) && (op_nxt != OP_MEM_WR);
               isWrite_nxt = (op_nxt == OP_MEM_WR) || (op_nxt == OP_TOK_WR)
                  || (op_nxt == OP_ACQUIRE) || (op_nxt == OP_INIT);
               // token requests write zero, init releases with one [RQ10]
               wrData_nxt = wdataReg_r;
               if (op_nxt == OP_ACQUIRE) begin
                  wrData_nxt = {{(DATA_W-1){1'b0}}, TOK_TAKE};
               end else if (op_nxt == OP_INIT) begin
                  wrData_nxt = {{(DATA_W-1){1'b0}}, TOK_FREE};
                  addrReg_nxt = '0;
               end
               // only the low three address bits pick a token [RQ11]
               if (isTok_nxt) begin
                  addrReg_nxt = {{(ADDR_W-TOK_SEL_W){1'b0}},
                                 addrReg_nxt[TOK_SEL_W-1:0]};
               end
               pins_nxt = phase_pins(addrReg_nxt, isTok_nxt, 1'b0, 1'b0);
               tmrLoad = 1'b1;
               tmrValue = SETUP_CYC;
               state_nxt = S_SETUP;
            end
         end
         S_SETUP: begin
            // address and enable settle before any strobe [RQ7]
            // a lost arbitration holds us here until busy lifts [RQ1]
            if (tmrExpired && !(roleMaster && !isTok_r && !busyIn)) begin
               pins_nxt = phase_pins(addrReg_r, isTok_r, isWrite_r, 1'b1);
               // semaphore write carries the value on bit zero [RQ12]
               dataOut_nxt = isTok_r ? {{(DATA_W-1){1'b0}}, wrData_r[0]}
                                     : wrData_r;
               dataOe_nxt = isWrite_r;
               tmrLoad = 1'b1;
               tmrValue = ACCESS_CYC;
               state_nxt = S_STROBE;
            end
         end
         S_STROBE: begin
            // select and output enable stay low till capture [RQ18]
            if (tmrExpired) begin
               if (!isWrite_r) begin
                  rdataReg_nxt = dataIn;
                  if (isTok_r) begin
                     spreadErr_nxt = !spread_ok(dataIn);  // [RQ17]
                     // zero read back means this port holds it [RQ13]
                     owned_nxt = (dataIn[0] == TOK_TAKE);
                  end
               end
               pins_nxt = PINS_IDLE;  // drop select between polls [RQ19]
               dataOe_nxt = 1'b0;
               tmrLoad = 1'b1;
               tmrValue = RECOVER_CYC;
               state_nxt = S_RECOVER;
            end
         end
         S_RECOVER: begin
            if (tmrExpired) begin
               tmrLoad = 1'b1;
               tmrValue = SETUP_CYC;
               state_nxt = S_SETUP;
               if (op_r == OP_ACQUIRE && isWrite_r) begin
                  // write then read back, never read then write [RQ10]
                  isWrite_nxt = 1'b0;
                  pins_nxt = phase_pins(addrReg_r, 1'b1, 1'b0, 1'b0);
               end else if (op_r == OP_INIT &&
                            addrReg_r[TOK_SEL_W-1:0] !=
                            TOK_SEL_W'(TOK_COUNT - 1)) begin
                  // free every token from this side
                  addrReg_nxt = addrReg_r + 1'b1;
                  pins_nxt = phase_pins(addrReg_nxt, 1'b1, 1'b1, 1'b0);
               end else begin
                  tmrLoad = 1'b0;
                  seqDone = 1'b1;
                  state_nxt = S_IDLE;
               end
            end
         end
      endcase
      // address register is writable only while idle
      if (regWrStb && regAddr == REG_ADDR && state_r == S_IDLE) begin
         addrReg_nxt = regWrData[ADDR_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file writes and status flags
   always_comb begin
      wdataReg_nxt = wdataReg_r;
      inhibit_nxt = inhibit_r;
      done_nxt = done_r;
      busySeen_nxt = busySeen_r;
      if (regWrStb) begin
         unique case (regAddr)
            REG_WDATA: wdataReg_nxt = regWrData[DATA_W-1:0];
            REG_CONFIG: inhibit_nxt = regWrData[CFG_INHIBIT];
            REG_STATUS: begin
               if (regWrData[ST_DONE]) begin
                  done_nxt = 1'b0;
               end
               if (regWrData[ST_BUSY_SEEN]) begin
                  busySeen_nxt = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // hardware set wins over software clear
      if (seqDone) begin
         done_nxt = 1'b1;
      end
      if (state_r == S_SETUP && roleMaster && !isTok_r && !busyIn) begin
         busySeen_nxt = 1'b1;  // [RQ2]
      end
   end

   // read data, present only in the cycle after the strobe
   always_comb begin
      regRdData_nxt = '0;
      if (regRdStb) begin
         unique case (regAddr)
            REG_ADDR: regRdData_nxt[ADDR_W-1:0] = addrReg_r;
            REG_WDATA: regRdData_nxt[DATA_W-1:0] = wdataReg_r;
            REG_RDATA: regRdData_nxt[DATA_W-1:0] = rdataReg_r;
            REG_STATUS: begin
               regRdData_nxt[ST_BUSY] = (state_r != S_IDLE);
               regRdData_nxt[ST_DONE] = done_r;
               regRdData_nxt[ST_OWNED] = owned_r;
               regRdData_nxt[ST_SPREAD_ERR] = spreadErr_r;
               regRdData_nxt[ST_BUSY_SEEN] = busySeen_r;
            end
            REG_CONFIG: regRdData_nxt[CFG_INHIBIT] = inhibit_r;
            default: regRdData_nxt = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= S_IDLE;
         op_r <= OP_MEM_RD;
         isWrite_r <= 1'b0;
         isTok_r <= 1'b0;
         pins_r <= PINS_IDLE;
         wrData_r <= '0;
         dataOut_r <= '0;
         dataOe_r <= 1'b0;
         addrReg_r <= '0;
         wdataReg_r <= '0;
         rdataReg_r <= '0;
         done_r <= 1'b0;
         owned_r <= 1'b0;
         spreadErr_r <= 1'b0;
         busySeen_r <= 1'b0;
         inhibit_r <= CFG_INHIBIT_RST;
         regRdData_r <= '0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         isWrite_r <= isWrite_nxt;
         isTok_r <= isTok_nxt;
         pins_r <= pins_nxt;
         wrData_r <= wrData_nxt;
         dataOut_r <= dataOut_nxt;
         dataOe_r <= dataOe_nxt;
         addrReg_r <= addrReg_nxt;
         wdataReg_r <= wdataReg_nxt;
         rdataReg_r <= rdataReg_nxt;
         done_r <= done_nxt;
         owned_r <= owned_nxt;
         spreadErr_r <= spreadErr_nxt;
         busySeen_r <= busySeen_nxt;
         inhibit_r <= inhibit_nxt;
         regRdData_r <= regRdData_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; busy pin driven only toward a slave part [RQ4]
   assign pins = pins_r;
   assign dataOut = dataOut_r;
   assign dataOe = dataOe_r;
   assign busyOe = ~roleMaster;  // master part drives busy itself [RQ25]
   assign busyOut = ~inhibit_r;
   assign regRdData = regRdData_r;
endmodule : dpram_port_host
`default_nettype wire

// *** core/pin_timer.sv ***
`default_nettype none
module pin_timer
   import dpram_host_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [W-1:0] loadValue,
   output logic expired
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // down counter, reload wins over counting
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = loadValue;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign expired = (cnt_r == '0);
endmodule : pin_timer
`default_nettype wire

// *** verification/dpram_dev_model.sv ***
`default_nettype none
module dpram_dev_model
   import dpram_host_pkg::*;
(
   input wire logic clk,
   input wire pins_type pins,
   input wire logic [DATA_W-1:0] bus,
   input wire logic busyPin,
   input wire logic roleMaster,
   input wire logic farCeN,
   input wire logic [ADDR_W-1:0] farAddr,
   input wire logic farSemWr,
   input wire logic [TOK_SEL_W-1:0] farSel,
   input wire logic farVal,
   output logic [DATA_W-1:0] rdData,
   output logic rdOe,
   output logic busyN,
   output logic [TOK_COUNT-1:0] farFlag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   // token latches apart from the array, host ones start taken
   logic [TOK_COUNT-1:0] reqH = '0, reqF = '1, ownH = '0, ownF = '0;
   logic farLead = 1'b0, tokLat = 1'b1, tokRdQ = 1'b0;
   logic match, hostLost, inhibit, tokSel, tokRd;
   logic [TOK_SEL_W-1:0] idx;

   // busy arbitration from enables and full address only
   assign match = !pins.chipEnN && !farCeN
      && pins.addr == farAddr;
   assign hostLost = match && farLead;
   assign busyN = !hostLost;
   assign inhibit = roleMaster ? hostLost : !busyPin;
   assign tokSel = !pins.tokenSpaceSelectN && pins.chipEnN;
   assign idx = pins.addr[TOK_SEL_W-1:0];
   assign tokRd = tokSel && !pins.outEnN && pins.rwN;
   // read path, quiet in standby
   assign rdOe = tokRd
      || (!pins.chipEnN && !pins.outEnN && pins.rwN);
   assign rdData = tokSel ? {DATA_W{tokRdQ ? tokLat : !ownH[idx]}}
      : mem[pins.addr];
   assign farFlag = ~ownF;

   ////////////////////////////////////////
   // writes, read latch and token hand-over
   always @(posedge clk) begin
      farLead <= !farCeN && (farLead || pins.chipEnN);
      tokRdQ <= tokRd;
      if (tokRd && !tokRdQ) tokLat <= !ownH[idx];
      if (!pins.chipEnN && !pins.rwN && !inhibit) begin
         mem[pins.addr] <= bus;
      end
      if (tokSel && !pins.rwN) reqH[idx] = bus[0];
      if (farSemWr) reqF[farSel] = farVal;
      for (int i = 0; i < TOK_COUNT; i++) begin
         if (ownH[i] && reqH[i]) ownH[i] = 1'b0;
         if (ownF[i] && reqF[i]) ownF[i] = 1'b0;
         if (!ownH[i] && !ownF[i]) begin
            ownH[i] = !reqH[i];
            ownF[i] = reqH[i] && !reqF[i];
         end
      end
   end
endmodule : dpram_dev_model
`default_nettype wire

// *** verification/dpram_port_host_properties.sv ***
`default_nettype none
module dpram_port_host_properties
   import dpram_host_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [REG_AW-1:0] regAddr,
   input wire logic [REG_DW-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [REG_DW-1:0] regRdData,
   input wire logic roleMaster,
   input wire pins_type pins,
   input wire logic [DATA_W-1:0] dataOut,
   input wire logic dataOe,
   input wire logic busyIn,
   input wire logic busyOut,
   input wire logic busyOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // strobe phase ends and recovery begins
   sequence strobe_end_s;
      (!pins.rwN || !pins.outEnN) ##1 (pins.rwN && pins.outEnN);
   endsequence
   // two write strobe cycles in a row
   sequence wr_held_s;
      !pins.rwN [*2];
   endsequence

   write_setup_a: assert property ($fell(pins.rwN) |->
      $past(pins.rwN && (!pins.chipEnN || !pins.tokenSpaceSelectN), 2))
      else $error("write pulse without setup");
   write_stable_a: assert property (wr_held_s |-> $stable(pins))
      else $error("pins moved during write pulse");
   recover_idle_a: assert property (strobe_end_s |->
      pins.chipEnN && pins.tokenSpaceSelectN && !dataOe)
      else $error("selects not dropped after strobe");
   drive_write_a: assert property (dataOe |-> !pins.rwN)
      else $error("data driven outside write pulse");
   token_addr_a: assert property (!pins.tokenSpaceSelectN |->
      pins.chipEnN && pins.addr[ADDR_W-1:TOK_SEL_W] == '0)
      else $error("token access with stray address");
   token_bit_a: assert property (dataOe && !pins.tokenSpaceSelectN
      |-> dataOut[DATA_W-1:1] == '0)
      else $error("token write drives upper bits");
   busy_enable_a: assert property (busyOe == !roleMaster)
      else $error("busy drive wrong for role");
   inhibit_level_a: assert property (regWrStb && regAddr == REG_CONFIG
      |=> busyOut == !$past(regWrData[CFG_INHIBIT]))
      else $error("inhibit not on busy pin");
   busy_stall_a: assert property (roleMaster && !busyIn &&
      $past(!busyIn) && !pins.chipEnN && pins.rwN && pins.outEnN
      |=> pins.rwN && pins.outEnN)
      else $error("strobe started while busy");
   read_idle_a: assert property (!$past(regRdStb) |-> regRdData == '0)
      else $error("read data outside its cycle");
endmodule : dpram_port_host_properties

bind dpram_port_host dpram_port_host_properties chk (.clk(clk),
   .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
   .roleMaster(roleMaster), .pins(pins), .dataOut(dataOut),
   .dataOe(dataOe), .busyIn(busyIn), .busyOut(busyOut), .busyOe(busyOe));
`default_nettype wire

// *** verification/dpram_port_host_tb.sv ***
`default_nettype none
module dpram_port_host_tb import dpram_host_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [REG_DW-1:0] val;
      logic [REG_DW-1:0] mask;
   } exp_type;
   logic clk = 1'b0, reset = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
   logic [REG_AW-1:0] regAddr = '0;
   logic [REG_DW-1:0] regWrData = '0, regRdData;
   logic roleMaster = 1'b0, farCeN = 1'b1, farSemWr = 1'b0, farVal = 1'b1;
   logic noteNow = 1'b0, chkPend = 1'b0, dataOe, rdOe, busyOut, busyOe;
   logic busyN, busyPin;
   logic [ADDR_W-1:0] farAddr = '0;
   logic [TOK_SEL_W-1:0] farSel = '0;
   logic [TOK_COUNT-1:0] farFlag;
   logic [DATA_W-1:0] dataOut, rdData, bus, lastBus = '0;
   pins_type pins;
   exp_type expQ [$];
   int fail_count = 0, n_checks = 0;

   // shared bus levels, a released bus keeps toggling
   assign bus = dataOe ? dataOut : rdOe ? rdData : ~lastBus;
   assign busyPin = busyOe ? busyOut : busyN;
   always @(posedge clk) lastBus <= bus;
   initial forever #2 clk = ~clk;

   dpram_port_host dut (.clk(clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .roleMaster(roleMaster), .pins(pins),
      .dataIn(bus), .dataOut(dataOut), .dataOe(dataOe), .busyIn(busyPin),
      .busyOut(busyOut), .busyOe(busyOe));
   dpram_dev_model dev (.clk(clk), .pins(pins), .bus(bus),
      .busyPin(busyPin), .roleMaster(roleMaster), .farCeN(farCeN),
      .farAddr(farAddr), .farSemWr(farSemWr), .farSel(farSel),
      .farVal(farVal), .rdData(rdData), .rdOe(rdOe), .busyN(busyN),
      .farFlag(farFlag));

   ////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic check(input string nm, input logic [REG_DW-1:0] e, g);
      n_checks++;
      if (e !== g) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk);
      regWrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [REG_AW-1:0] a,
                     input logic [REG_DW-1:0] e, m);
      @(posedge clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      noteNow <= 1'b1;
      expQ.push_back('{e, m});
      @(posedge clk);
      regRdStb <= 1'b0;
      noteNow <= 1'b0;
   endtask : rd
   task automatic wait_done;
      logic [REG_DW-1:0] v = '0;
      for (int n = 0; n < 300 && v[ST_DONE] !== 1'b1; n++) begin
         @(posedge clk);
         regAddr <= REG_STATUS;
         regRdStb <= 1'b1;
         @(posedge clk);
         regRdStb <= 1'b0;
         @(posedge clk);
         v = regRdData;
      end
      if (v[ST_DONE] !== 1'b1) begin
         fail_count++;
         end_sim();
      end
      wr(REG_STATUS, 32'h1 << ST_DONE | 32'h1 << ST_BUSY_SEEN);
   endtask : wait_done
   task automatic cmd(input op_type op, input logic [REG_DW-1:0] a, d);
      wr(REG_ADDR, a);
      wr(REG_WDATA, d);
      wr(REG_CMD, REG_DW'(op));
      wait_done();
   endtask : cmd
   task automatic tok_see(input logic [REG_DW-1:0] a, input logic own);
      cmd(OP_TOK_RD, a, '0);
      rd(REG_STATUS, REG_DW'({own, 2'b00}), 32'hc);
      rd(REG_RDATA, REG_DW'({DATA_W{!own}}), '1);
   endtask : tok_see
   task automatic far_tok(input int i, input logic v);
      @(posedge clk);
      farSel <= i[TOK_SEL_W-1:0];
      farVal <= v;
      farSemWr <= 1'b1;
      @(posedge clk);
      farSemWr <= 1'b0;
   endtask : far_tok

   // read results against the oldest note
   always @(posedge clk) begin
      exp_type e;
      if (chkPend) begin
         e = expQ.pop_front();
         check("regRdData", e.val & e.mask, regRdData & e.mask);
      end
      chkPend <= regRdStb && noteNow;
   end

   initial begin
      logic [DATA_W-1:0] d1, d2;
      logic [ADDR_W-1:0] a1;
      void'($urandom(81931));
      d1 = DATA_W'($urandom());
      d2 = ~d1;
      a1 = ADDR_W'($urandom());
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(REG_CONFIG, '0, '1);
      wr(4'hf, '1);
      rd(4'hf, '0, '1);
      $display("test registers done");
      cmd(OP_MEM_WR, REG_DW'(a1), REG_DW'(d1));
      cmd(OP_MEM_RD, REG_DW'(a1), '0);
      rd(REG_RDATA, REG_DW'(d1), '1);
      $display("test memory done");
      for (int i = 0; i < TOK_COUNT; i++) far_tok(i, TOK_FREE);
      cmd(OP_INIT, '0, '0);
      for (int i = 0; i < TOK_COUNT; i++) tok_see(REG_DW'(i), 1'b0);
      check("farFlag", REG_DW'({TOK_COUNT{1'b1}}), REG_DW'(farFlag));
      $display("test token init done");
      cmd(OP_ACQUIRE, REG_DW'({a1[ADDR_W-1:TOK_SEL_W], 3'h3}), '0);
      rd(REG_STATUS, 32'h4, 32'hc);
      check("farFlag3", 32'h1, REG_DW'(farFlag[3]));
      far_tok(3, TOK_TAKE);
      check("farFlag3", 32'h1, REG_DW'(farFlag[3]));
      cmd(OP_TOK_WR, 32'h3, '1);
      check("farFlag3", 32'h0, REG_DW'(farFlag[3]));
      tok_see(32'h3, 1'b0);
      cmd(OP_ACQUIRE, 32'h3, '0);
      rd(REG_STATUS, 32'h0, 32'h4);
      far_tok(3, TOK_FREE);
      tok_see(32'h3, 1'b1);
      cmd(OP_TOK_WR, 32'h3, 32'h1);
      tok_see(32'h3, 1'b0);
      check("farFlag3", 32'h1, REG_DW'(farFlag[3]));
      $display("test token passing done");
      wr(REG_CONFIG, 32'h1);
      @(posedge clk);
      check("busyPin", 32'h0, REG_DW'(busyPin));
      cmd(OP_MEM_WR, REG_DW'(a1), REG_DW'(d2));
      cmd(OP_MEM_RD, REG_DW'(a1), '0);
      rd(REG_RDATA, REG_DW'(d1), '1);
      wr(REG_CONFIG, '0);
      cmd(OP_MEM_WR, REG_DW'(a1), REG_DW'(d2));
      cmd(OP_MEM_RD, REG_DW'(a1), '0);
      rd(REG_RDATA, REG_DW'(d2), '1);
      $display("test write inhibit done");
      roleMaster <= 1'b1;
      farAddr <= a1;
      farCeN <= 1'b0;
      wr(REG_ADDR, REG_DW'(a1));
      wr(REG_WDATA, REG_DW'(d1));
      wr(REG_CMD, REG_DW'(OP_MEM_WR));
      repeat (20) @(posedge clk);
      rd(REG_STATUS, 32'h11, 32'h13);
      check("pins.rwN", 32'h1, REG_DW'(pins.rwN));
      farCeN <= 1'b1;
      wait_done();
      cmd(OP_MEM_RD, REG_DW'(a1), '0);
      rd(REG_RDATA, REG_DW'(d1), '1);
      repeat (4) @(posedge clk);
      $display("test busy done");
      end_sim();
   end
endmodule : dpram_port_host_tb
`default_nettype wire
